// ===== src/tap_pkg.sv
// constants and types shared by the test access port modules
package tap_pkg;

  // instruction register width and codes
  localparam int IR_W = 4;
  localparam logic [IR_W-1:0] INSN_EXTEST = 4'h0;
  localparam logic [IR_W-1:0] INSN_SAMPLE = 4'h2;
  localparam logic [IR_W-1:0] INSN_HIGHZ = 4'h9;
  localparam logic [IR_W-1:0] INSN_CLAMP = 4'hc;
  localparam logic [IR_W-1:0] INSN_BYPASS = 4'hf;
  // fixed pattern loaded into the instruction shifter in capture-ir
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h1;

  // boundary register length, cell 0 is shifted out first
  localparam int BSR_LEN = 62;
  localparam int BSR_FIRST_CELL = 0;

  // synchroniser depth for pin inputs
  localparam int SYNC_STAGES = 2;

  // reset values
  localparam logic TDO_RESET = 1'b0;
  localparam logic PIN_SYNC_RESET = 1'b1;

  // controller states, one-hot
  typedef enum logic [15:0] {
    ST_TLR        = 16'h0001,
    ST_RTI        = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAPTURE_DR = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAPTURE_IR = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } tap_state_t;

endpackage

// ===== src/tap_if.sv
// carrier between the controller state machine and the scan datapath
`timescale 1ns/1ps
`default_nettype none

interface tap_if;
  import tap_pkg::*;

  logic tck_rise;
  logic tms;
  logic trst;
  tap_state_t state;

  // state machine side
  modport fsm (
    input tck_rise,
    input tms,
    input trst,
    output state
  );

  // datapath side
  modport core (
    output tck_rise,
    output tms,
    output trst,
    input state
  );
endinterface

`default_nettype wire

// ===== src/pin_sync.sv
// two-stage synchroniser for pins from outside the clock domain
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);
  import tap_pkg::*;

  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] q_reg;

  // first stage feeds only the second stage
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      meta_reg <= {WIDTH{PIN_SYNC_RESET}};
      q_reg <= {WIDTH{PIN_SYNC_RESET}};
    end else begin
      meta_reg <= d;
      q_reg <= meta_reg;
    end
  end

  assign q = q_reg;
endmodule // pin_sync

`default_nettype wire

// ===== src/tap_fsm.sv
// sixteen-state test access port controller
`timescale 1ns/1ps
`default_nettype none

module tap_fsm (
  input wire logic ref_clk,
  input wire logic reset,
  tap_if.fsm bus
);
  import tap_pkg::*;

  tap_state_t state_reg;
  tap_state_t state_next;

  ////////////////////////////////////////////////////////////////
  // next state, chosen by tms at the test clock rising edge
  always_comb begin
    state_next = state_reg;
    if (bus.tck_rise) begin
      case (state_reg)
        ST_TLR:        state_next = bus.tms ? ST_TLR : ST_RTI;
        ST_RTI:        state_next = bus.tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_DR:     state_next = bus.tms ? ST_SEL_IR : ST_CAPTURE_DR;
        ST_CAPTURE_DR: state_next = bus.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_SHIFT_DR:   state_next = bus.tms ? ST_EXIT1_DR : ST_SHIFT_DR;
        ST_EXIT1_DR:   state_next = bus.tms ? ST_UPDATE_DR : ST_PAUSE_DR;
        ST_PAUSE_DR:   state_next = bus.tms ? ST_EXIT2_DR : ST_PAUSE_DR;
        ST_EXIT2_DR:   state_next = bus.tms ? ST_UPDATE_DR : ST_SHIFT_DR;
        ST_UPDATE_DR:  state_next = bus.tms ? ST_SEL_DR : ST_RTI;
        ST_SEL_IR:     state_next = bus.tms ? ST_TLR : ST_CAPTURE_IR;
        ST_CAPTURE_IR: state_next = bus.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_SHIFT_IR:   state_next = bus.tms ? ST_EXIT1_IR : ST_SHIFT_IR;
        ST_EXIT1_IR:   state_next = bus.tms ? ST_UPDATE_IR : ST_PAUSE_IR;
        ST_PAUSE_IR:   state_next = bus.tms ? ST_EXIT2_IR : ST_PAUSE_IR;
        ST_EXIT2_IR:   state_next = bus.tms ? ST_UPDATE_IR : ST_SHIFT_IR;
        ST_UPDATE_IR:  state_next = bus.tms ? ST_SEL_DR : ST_RTI;
        default:       state_next = ST_TLR;
      endcase
    end
  end

  // state register, test reset overrides everything
  always_ff @(posedge ref_clk) begin
    if (reset || bus.trst) begin
      state_reg <= ST_TLR;
    end else begin
      state_reg <= state_next;
    end
  end

  assign bus.state = state_reg;
endmodule // tap_fsm

`default_nettype wire

// ===== src/boundary_scan_tap.sv
// test access port with instruction, bypass and boundary scan registers
//
// Overview of operation
// - shift-ir puts the instruction shifter between tdi and tdo
// - test reset pin forces the controller into test-logic-reset
// - tdo is driven only in shift-ir and shift-dr, else floating
// - tdo drive and enable change on the test clock falling edge
// - code 1111 is bypass and is the instruction after power-up
// - bypass puts a one-bit register between tdi and tdo in shift-dr
// - code 0010 samples/preloads the boundary register without disturbing pins
// - boundary register is 62 cells, one per functional pin or control
// - boundary instructions capture pins in capture-dr and shift in shift-dr
// - cell for the output-enable pin is bit 0, first out on tdo
// - code 0000 is extest, boundary register in the serial path
// - extest: a test clock in run-test/idle samples inputs; outputs stay on the update latch
// - extest uses only the test clock; the functional clock is just a cell
// - code 1100 clamps outputs from the boundary register, bypass serial path
// - code 1001 floats all outputs, bypass register in serial path
// - tms and tdi are sampled at the test clock rising edge
// - an undriven tms or tdi reads as logic one
// - five tms-high clocks reach test-logic-reset; core logic untouched by resets
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap #(
  parameter int CELLS = tap_pkg::BSR_LEN,
  parameter logic [tap_pkg::BSR_LEN-1:0] OUT_CELL_MASK = {tap_pkg::BSR_LEN{1'b1}}
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  output logic tdo_o,
  output logic tdo_oe,
  input wire logic [tap_pkg::BSR_LEN-1:0] core_do,
  input wire logic [tap_pkg::BSR_LEN-1:0] core_oe,
  input wire logic [tap_pkg::BSR_LEN-1:0] pad_di,
  output logic [tap_pkg::BSR_LEN-1:0] pad_do,
  output logic [tap_pkg::BSR_LEN-1:0] pad_oe
);
  import tap_pkg::*;

  ////////////////////////////////////////////////////////////////
  // declarations

  tap_if bus ();

  logic [3:0] tap_pins_s;
  logic [BSR_LEN-1:0] pad_s;
  logic tck_s;
  logic tms_s;
  logic tdi_s;
  logic trst_n_s;
  logic tck_prev_reg;
  logic tck_rise;
  logic tck_fall;

  logic [IR_W-1:0] ir_reg;
  logic [IR_W-1:0] ir_next;
  logic [IR_W-1:0] ir_shift_reg;
  logic [IR_W-1:0] ir_shift_next;
  logic bypass_reg;
  logic bypass_next;
  logic [BSR_LEN-1:0] bsr_reg;
  logic [BSR_LEN-1:0] bsr_next;
  logic [BSR_LEN-1:0] upd_reg;
  logic [BSR_LEN-1:0] upd_next;
  logic tdo_reg;
  logic tdo_next;
  logic tdo_oe_reg;
  logic tdo_oe_next;
  logic [BSR_LEN-1:0] pad_do_reg;
  logic [BSR_LEN-1:0] pad_do_next;
  logic [BSR_LEN-1:0] pad_oe_reg;
  logic [BSR_LEN-1:0] pad_oe_next;

  ////////////////////////////////////////////////////////////////
  // pin synchronisers; pads pull tms and tdi high when left floating

  pin_sync #(
    .WIDTH(4)
  ) u_tap_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .d({trst_n, ~tck, tms, tdi}),  // tck enters inverted so its reset level is the idle low
    .q(tap_pins_s)
  );

  pin_sync #(
    .WIDTH(BSR_LEN)
  ) u_pad_sync (
    .ref_clk(ref_clk),
    .reset(reset),
    .d(pad_di),
    .q(pad_s)
  );

  // unpack the synchronised test pins; reset value of one matches a float
  assign trst_n_s = tap_pins_s[3];
  assign tck_s = ~tap_pins_s[2];  // low in reset like the idle pin, so no false edge after release
  assign tms_s = tap_pins_s[1];
  assign tdi_s = tap_pins_s[0];

  // previous test clock level for edge detection
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      tck_prev_reg <= 1'b0;
    end else begin
      tck_prev_reg <= tck_s;
    end
  end

  // test clock edges; tms and tdi are used only at the rising one
  assign tck_rise = tck_s & ~tck_prev_reg;
  assign tck_fall = ~tck_s & tck_prev_reg;

  ////////////////////////////////////////////////////////////////
  // controller

  assign bus.tck_rise = tck_rise;
  assign bus.tms = tms_s;
  assign bus.trst = ~trst_n_s;

  tap_fsm u_fsm (
    .ref_clk(ref_clk),
    .reset(reset),
    .bus(bus.fsm)
  );

  ////////////////////////////////////////////////////////////////
  // state and instruction decode

  wire st_tlr = (bus.state == ST_TLR);
  wire st_rti = (bus.state == ST_RTI);
  wire st_cap_dr = (bus.state == ST_CAPTURE_DR);
  wire st_shift_dr = (bus.state == ST_SHIFT_DR);
  wire st_upd_dr = (bus.state == ST_UPDATE_DR);
  wire st_cap_ir = (bus.state == ST_CAPTURE_IR);
  wire st_shift_ir = (bus.state == ST_SHIFT_IR);
  wire st_upd_ir = (bus.state == ST_UPDATE_IR);

  wire is_extest = (ir_reg == INSN_EXTEST);
  wire is_sample = (ir_reg == INSN_SAMPLE);
  wire is_clamp = (ir_reg == INSN_CLAMP);
  wire is_highz = (ir_reg == INSN_HIGHZ);
  // boundary register is in the path only for extest and sample
  wire sel_bsr = is_extest | is_sample;
  // everything else, listed or not, uses the bypass cell
  wire sel_bypass = ~sel_bsr;
  // outputs follow the update latch under extest and clamp
  wire drive_upd = is_extest | is_clamp;

  ////////////////////////////////////////////////////////////////
  // instruction register: shifter plus active latch

  always_comb begin
    ir_shift_next = ir_shift_reg;
    if (tck_rise && st_cap_ir) begin
      ir_shift_next = IR_CAPTURE;
    end else if (tck_rise && st_shift_ir) begin
      ir_shift_next = {tdi_s, ir_shift_reg[IR_W-1:1]};
    end
  end

  // latch on the falling edge in update-ir, back to bypass in reset state
  always_comb begin
    ir_next = ir_reg;
    if (st_tlr) begin
      ir_next = INSN_BYPASS;
    end else if (tck_fall && st_upd_ir) begin
      ir_next = ir_shift_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ir_shift_reg <= IR_CAPTURE;
      ir_reg <= INSN_BYPASS;
    end else begin
      ir_shift_reg <= ir_shift_next;
      ir_reg <= ir_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // bypass cell: zero on capture, one-bit delay on shift

  always_comb begin
    bypass_next = bypass_reg;
    if (tck_rise && sel_bypass && st_cap_dr) begin
      bypass_next = 1'b0;
    end else if (tck_rise && sel_bypass && st_shift_dr) begin
      bypass_next = tdi_s;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bypass_reg <= 1'b0;
    end else begin
      bypass_reg <= bypass_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // boundary register: capture pins, shift toward cell 0

  always_comb begin
    bsr_next = bsr_reg;
    if (tck_rise && sel_bsr && st_cap_dr) begin
      bsr_next = pad_s;
    end else if (tck_rise && is_extest && st_rti) begin
      // functional clock pin is only one more sampled cell here
      bsr_next = pad_s;
    end else if (tck_rise && sel_bsr && st_shift_dr) begin
      bsr_next = {tdi_s, bsr_reg[BSR_LEN-1:1]};
    end
  end

  // update latch, loaded on the falling edge in update-dr
  always_comb begin
    upd_next = upd_reg;
    if (tck_fall && sel_bsr && st_upd_dr) begin
      upd_next = bsr_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bsr_reg <= '0;
      upd_reg <= '0;
    end else begin
      bsr_reg <= bsr_next;
      upd_reg <= upd_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // serial output, retimed on the falling test clock edge

  wire shift_any = st_shift_ir | st_shift_dr;
  wire serial_bit = st_shift_ir ? ir_shift_reg[0] :
                    sel_bsr ? bsr_reg[BSR_FIRST_CELL] : bypass_reg;

  always_comb begin
    tdo_next = tdo_reg;
    tdo_oe_next = tdo_oe_reg;
    if (tck_fall) begin
      tdo_next = shift_any ? serial_bit : TDO_RESET;
      tdo_oe_next = shift_any;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset || bus.trst) begin
      tdo_reg <= TDO_RESET;
      tdo_oe_reg <= 1'b0;
    end else begin
      tdo_reg <= tdo_next;
      tdo_oe_reg <= tdo_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pad drive: core path, update latch or float, per cell

  genvar c;
  generate
    for (c = 0; c < BSR_LEN; c = c + 1) begin : g_cell
      // core keeps the pins unless a test instruction takes them
      assign pad_do_next[c] = drive_upd ? upd_reg[c] : core_do[c];
      assign pad_oe_next[c] = is_highz ? 1'b0 :
                              drive_upd ? OUT_CELL_MASK[c] : core_oe[c];
    end
  endgenerate

  // pad registers; sample and bypass leave the core path untouched
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      pad_do_reg <= '0;
      pad_oe_reg <= '0;
    end else begin
      pad_do_reg <= pad_do_next;
      pad_oe_reg <= pad_oe_next;
    end
  end

  ////////////////////////////////////////////////////////////////
  // outputs

  assign tdo_o = tdo_reg;
  assign tdo_oe = tdo_oe_reg;
  assign pad_do = pad_do_reg;
  assign pad_oe = pad_oe_reg;

endmodule // boundary_scan_tap

`default_nettype wire

// ===== testbench/jtag_ctl_model.sv
// board-level test controller model driving the test access port pins
`timescale 1ns/1ps
`default_nettype none

module jtag_ctl_model (
  input wire logic ref_clk,
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo_o,
  input wire logic tdo_oe
);
  // clock stands still low outside frames, pulled-up lines idle high
  initial begin
    tck <= 1'b0;
    tms <= 1'b1;
    tdi <= 1'b1;
  end

  // one 160 ns test clock of eight system clocks, entered and left on a system clock edge;
  // tms and tdi settle two edges ahead of the rise, tdo is read three edges into the high phase
  task automatic tick(input logic m, input logic d, output logic q, output logic e);
    tms <= m;
    tdi <= d;
    repeat (2) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (3) @(posedge ref_clk);
    q = tdo_oe ? tdo_o : 1'bz;
    e = tdo_oe;
    @(posedge ref_clk);
    tck <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask

  // lines released after a frame fall back to the pull-up level
  task automatic release_lines();
    tms <= 1'b1;
    tdi <= 1'b1;
    @(posedge ref_clk);
  endtask
endmodule // jtag_ctl_model

`default_nettype wire

// ===== testbench/boundary_scan_tap_asserts.sv
// concurrent checks on the test access port top-level pins
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap_asserts
  import tap_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic trst_n,
  input wire logic tdo_o,
  input wire logic tdo_oe,
  input wire logic [BSR_LEN-1:0] core_do,
  input wire logic [BSR_LEN-1:0] core_oe,
  input wire logic [BSR_LEN-1:0] pad_di,
  input wire logic [BSR_LEN-1:0] pad_do,
  input wire logic [BSR_LEN-1:0] pad_oe
);
  logic [2:0] tck_q;
  logic [1:0] tms_q;
  logic [2:0] high_cnt_reg;
  logic [2:0] high_cnt_next;
  wire rise_seen = tck_q[1] & ~tck_q[2];

  default clocking dclk @(posedge ref_clk); endclocking
  default disable iff (reset);

  // count test clock rises with tms high, saturating at five
  assign high_cnt_next = !rise_seen ? high_cnt_reg : !tms_q[1] ? 3'h0 :
                         (high_cnt_reg == 3'h5) ? 3'h5 : high_cnt_reg + 3'h1;
  always_ff @(posedge ref_clk) begin
    tck_q <= reset ? 3'h0 : {tck_q[1:0], tck};
    tms_q <= reset ? 2'h0 : {tms_q[0], tms};
    high_cnt_reg <= reset ? 3'h0 : high_cnt_next;
  end

  sequence trst_held;
    !trst_n [*8];
  endsequence
  sequence five_high;
    high_cnt_reg == 3'h5 && $past(high_cnt_reg, 6) == 3'h5;
  endsequence

  reset_clears_a: assert property (disable iff (1'b0) reset |=> !tdo_oe && tdo_o == TDO_RESET && pad_oe == '0)
    else $error("outputs not cleared by reset");
  oe_fall_edge_a: assert property ($changed(tdo_oe) |-> !$past(tck, 2) && !$past(tck, 3))
    else $error("tdo enable moved away from a test clock fall");
  tdo_fall_edge_a: assert property ($changed(tdo_o) |-> !$past(tck, 2) && !$past(tck, 3))
    else $error("tdo moved away from a test clock fall");
  tdo_steady_a: assert property ($rose(tck) |=> $stable(tdo_o) [*3])
    else $error("tdo changed while test clock high");
  trst_quiet_a: assert property (trst_held |-> !tdo_oe)
    else $error("tdo driven during test reset");
  trst_bypass_a: assert property (trst_held |-> pad_do == $past(core_do) && pad_oe == $past(core_oe))
    else $error("pads not on core path during test reset");
  release_bypass_a: assert property ($fell(reset) |=> pad_do == $past(core_do))
    else $error("pads not on core path after reset");
  tms_reset_a: assert property (five_high |-> !tdo_oe && pad_oe == $past(core_oe))
    else $error("five tms-high clocks did not reach test reset");
endmodule // boundary_scan_tap_asserts

bind boundary_scan_tap boundary_scan_tap_asserts chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .tck(tck),
  .tms(tms),
  .tdi(tdi),
  .trst_n(trst_n),
  .tdo_o(tdo_o),
  .tdo_oe(tdo_oe),
  .core_do(core_do),
  .core_oe(core_oe),
  .pad_di(pad_di),
  .pad_do(pad_do),
  .pad_oe(pad_oe)
);

`default_nettype wire

// ===== testbench/boundary_scan_tap_test.sv
// self-checking bench for the test access port against a queue model
`timescale 1ns/1ps
`default_nettype none

module boundary_scan_tap_test;
  import tap_pkg::*;

  logic ref_clk = 1'b0;
  logic reset = 1'b1;
  logic trst_n = 1'b1;
  logic tck, tms, tdi, tdo_o, tdo_oe;
  logic [BSR_LEN-1:0] core_do = '0;
  logic [BSR_LEN-1:0] core_oe = '0;
  logic [BSR_LEN-1:0] pad_di = '0;
  logic [BSR_LEN-1:0] pad_do, pad_oe, pdi, latch_m;
  logic [IR_W-1:0] ir_m;
  logic [IR_W-1:0] codes [6] = '{INSN_SAMPLE, INSN_EXTEST, INSN_CLAMP, INSN_HIGHZ, 4'h5, INSN_BYPASS};
  logic [31:0] seed = 32'h17eafd18;
  logic mq[$];
  int n_errors = 0;
  int total_checks = 0;
  int cyc = 0;

  always #10 ref_clk = ~ref_clk;

  boundary_scan_tap dut (.ref_clk(ref_clk), .reset(reset), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo_o(tdo_o), .tdo_oe(tdo_oe), .core_do(core_do), .core_oe(core_oe), .pad_di(pad_di), .pad_do(pad_do),
    .pad_oe(pad_oe));
  jtag_ctl_model pm (.ref_clk(ref_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo_o(tdo_o), .tdo_oe(tdo_oe));

  ////////////////////////////////////////////////////////////
  // verdict, compares and random source
  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk1(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chkv(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [63:0] rnd64();
    for (int i = 0; i < 2; i++) seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return {seed, seed[15:0], seed[31:16]};
  endfunction

  ////////////////////////////////////////////////////////////
  // serial path model: pop one bit out, push the tdi bit in
  function automatic logic [63:0] model(input int n, input logic [63:0] din);
    logic [63:0] r;
    r = '0;
    for (int i = 0; i < n; i++) begin
      r[i] = mq.pop_front();
      mq.push_back(din[i]);
    end
    return r;
  endfunction

  // one test clock, tdo enable expected only in shift states
  task automatic tk(input logic m, input logic d, input logic sh, output logic q);
    logic e;
    pm.tick(m, d, q, e);
    chk1(e, sh);
  endtask

  // walk from idle through capture, shift n bits, update, back to idle
  task automatic scan(input bit is_ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic q;
    dout = '0;
    @(posedge ref_clk);
    tk(1'b1, 1'b1, 1'b0, q);
    if (is_ir) begin
      tk(1'b1, 1'b1, 1'b0, q);
    end
    tk(1'b0, 1'b1, 1'b0, q);
    tk(1'b0, 1'b1, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tk(i == n - 1, din[i], 1'b1, q);
      dout[i] = q;
    end
    tk(1'b1, 1'b1, 1'b0, q);
    tk(1'b0, 1'b1, 1'b0, q);
    pm.release_lines();
  endtask

  task automatic load(input logic [IR_W-1:0] code);
    logic [63:0] got, exp;
    mq = {1'b1, 1'b0, 1'b0, 1'b0};
    exp = model(IR_W, 64'(code));
    scan(1'b1, IR_W, 64'(code), got);
    chkv(got, exp);
    ir_m = code;
  endtask

  task automatic dr(input int n);
    logic [63:0] din, got, exp;
    logic bsr;
    bsr = ir_m == INSN_EXTEST || ir_m == INSN_SAMPLE;
    din = rnd64();
    mq = {};
    if (bsr) begin
      for (int i = 0; i < BSR_LEN; i++) mq.push_back(pdi[i]);
    end else begin
      mq.push_back(1'b0);
    end
    exp = model(n, din);
    scan(1'b0, n, din, got);
    chkv(got, exp);
    if (bsr) begin
      for (int i = 0; i < BSR_LEN; i++) latch_m[i] = mq[i];
    end
  endtask

  // pad outputs per instruction: latch, floating or core path
  task automatic pads();
    logic [BSR_LEN-1:0] ed, eo;
    logic hold;
    repeat (3) @(posedge ref_clk);
    hold = ir_m == INSN_EXTEST || ir_m == INSN_CLAMP;
    ed = hold ? latch_m : core_do;
    eo = hold ? '1 : (ir_m == INSN_HIGHZ) ? '0 : core_oe;
    chkv(64'(pad_oe), 64'(eo));
    if (ir_m != INSN_HIGHZ) begin
      chkv(64'(pad_do), 64'(ed));
    end
  endtask

  task automatic drive();
    logic [63:0] a, b, c;
    a = rnd64();
    b = rnd64();
    c = rnd64();
    @(posedge ref_clk);
    core_do <= a[BSR_LEN-1:0];
    core_oe <= b[BSR_LEN-1:0];
    pad_di <= c[BSR_LEN-1:0];
    pdi = c[BSR_LEN-1:0];
  endtask

  ////////////////////////////////////////////////////////////
  // hang guard
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors = n_errors + 1;
      close_out();
    end
  end

  // main sequence: every instruction, tms reset, test reset pin
  initial begin
    logic q;
    ir_m = INSN_BYPASS;
    latch_m = '0;
    repeat (3) @(posedge ref_clk);
    reset <= 1'b0;
    drive();
    pads();
    @(posedge ref_clk);
    tk(1'b0, 1'b1, 1'b0, q);
    foreach (codes[k]) begin
      drive();
      load(codes[k]);
      pads();
      dr((ir_m == INSN_EXTEST || ir_m == INSN_SAMPLE) ? 64 : 24);
      pads();
    end
    load(INSN_EXTEST);
    repeat (5) tk(1'b1, 1'b1, 1'b0, q);
    ir_m = INSN_BYPASS;
    pads();
    tk(1'b0, 1'b1, 1'b0, q);
    load(INSN_CLAMP);
    @(posedge ref_clk);
    trst_n <= 1'b0;
    repeat (10) @(posedge ref_clk);
    trst_n <= 1'b1;
    ir_m = INSN_BYPASS;
    pads();
    close_out();
  end
endmodule // boundary_scan_tap_test

`default_nettype wire
